// ---- dv/sbw_alu_tb.sv ----
// Purpose: Self-checking bench for the subtract and sleep datapath slice.
// Assumes: Inputs change on the falling edge; file data valid in Q2.
// Notes: A running model of W and the five flags feeds the expected values in run; some checks use fixed values.
`default_nettype none
module sbw_alu_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i, rst_n_i, instr_valid_i, wake_i, wake_by_watchdog_i;
	logic [15:0] instr_i;
	logic [3:0] bank_select_register_i;
	logic [7:0] file_rdata_i;
	logic instr_ready_o, file_rd_o, file_we_o, timeout_status_bit_o;
	logic powerdown_status_bit_o, watchdog_counter_clr_o, osc_stop_o;
	logic [3:0] phase_o;
	logic [11:0] file_addr_o;
	logic [7:0] file_wdata_o, working_register_o;
	sbw_pkg::sbw_flags_type flags_o, fl;
	logic [7:0] w;
	int err_count, checked, cycles;

	sbw_alu i_sbw_alu (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i),
		.bank_select_register_i(bank_select_register_i),
		.file_rdata_i(file_rdata_i), .wake_i(wake_i),
		.wake_by_watchdog_i(wake_by_watchdog_i),
		.instr_ready_o(instr_ready_o), .phase_o(phase_o),
		.file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
		.file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
		.working_register_o(working_register_o), .flags_o(flags_o),
		.timeout_status_bit_o(timeout_status_bit_o),
		.powerdown_status_bit_o(powerdown_status_bit_o),
		.watchdog_counter_clr_o(watchdog_counter_clr_o),
		.osc_stop_o(osc_stop_o));

	// 100 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard, far above the 62 cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count = err_count + 1;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// One whole instruction from Q1; kind 0 borrow, 1 file, 2 literal
	task automatic run(input int kind, input logic d, input logic a,
			input logic [7:0] f, input logic [7:0] fd);
		logic [15:0] ins;
		logic [7:0] x, y, r;
		logic ci, wf;
		logic [8:0] s;
		logic [4:0] h;
		logic [11:0] ea;
		sbw_pkg::sbw_flags_type ef;
		case (kind)
			0: begin
				ins = {6'h15, d, a, f};
				x = w;
				y = fd;
				ci = fl.c;
			end
			1: begin
				ins = {6'h17, d, a, f};
				x = fd;
				y = w;
				ci = 1'b1;
			end
			default: begin
				ins = {8'h08, f};
				x = f;
				y = w;
				ci = 1'b1;
			end
		endcase
		// Subtract as add of inverse plus carry: C high means no borrow
		s = {1'b0, x} + {1'b0, ~y} + {8'h00, ci};
		h = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
		r = s[7:0];
		ef = {r[7], (x[7] != y[7]) && (r[7] != x[7]), r == 8'h00, h[4], s[8]};
		ea = a ? {bank_select_register_i, f} :
			(f < 8'h80 ? {4'h0, f} : {4'hF, f});
		wf = (kind != 2) && d;
		instr_valid_i = 1'b1;
		instr_i = ins;
		file_rdata_i = fd;
		chk(instr_ready_o, 1);
		@(negedge sys_clk_i);
		instr_valid_i = 1'b0;
		chk(file_rd_o, kind != 2);
		if (kind != 2)
			chk(file_addr_o, ea);
		@(negedge sys_clk_i);
		file_rdata_i = ~fd;
		@(negedge sys_clk_i);
		chk(file_we_o, wf);
		if (wf)
			chk(file_wdata_o, r);
		@(negedge sys_clk_i);
		if (!wf)
			w = r;
		fl = ef;
		chk(working_register_o, w);
		chk(flags_o, fl);
		chk(phase_o, 1);
	endtask

	// Literal cases: positive, negative, signed overflow, zero
	task automatic t_literal();
		run(2, 1'b0, 1'b0, 8'h03, 8'h00);
		run(2, 1'b1, 1'b1, 8'h02, 8'h00);
		// Fixed values, independent of the running model
		chk(working_register_o, 16'h00FF);
		chk(flags_o, 16'h0010);
		run(2, 1'b0, 1'b0, 8'h7F, 8'h00);
		run(2, 1'b0, 1'b0, 8'h80, 8'h00);
		chk(working_register_o, 16'h0000);
		chk(flags_o, 16'h0007);
	endtask

	// Borrow chain through both banks and both destinations
	task automatic t_borrow();
		run(0, 1'b1, 1'b0, 8'h90, 8'h03);
		run(0, 1'b0, 1'b1, 8'h12, 8'h02);
		// Zero minus two minus a pending borrow
		chk(working_register_o, 16'h00FD);
		chk(flags_o, 16'h0010);
		run(0, 1'b0, 1'b0, 8'h10, 8'hFC);
		run(0, 1'b1, 1'b0, 8'h05, 8'h00);
	endtask

	task automatic t_file();
		run(1, 1'b1, 1'b1, 8'hFF, 8'h01);
		run(1, 1'b0, 1'b0, 8'h7F, 8'h05);
	endtask

	// Sleep, a refused request while asleep, then wake
	task automatic t_sleep(input logic wdog);
		instr_valid_i = 1'b1;
		instr_i = 16'h0003;
		repeat (4) @(negedge sys_clk_i);
		instr_i = 16'h08AA;
		chk(powerdown_status_bit_o, 0);
		chk(timeout_status_bit_o, 1);
		chk(watchdog_counter_clr_o, 1);
		chk(osc_stop_o, 1);
		chk(instr_ready_o, 0);
		repeat (3) @(negedge sys_clk_i);
		chk(watchdog_counter_clr_o, 0);
		instr_valid_i = 1'b0;
		wake_i = 1'b1;
		wake_by_watchdog_i = wdog;
		@(negedge sys_clk_i);
		wake_i = 1'b0;
		wake_by_watchdog_i = 1'b0;
		chk(osc_stop_o, 0);
		chk(timeout_status_bit_o, !wdog);
		chk(phase_o, 1);
		chk(working_register_o, w);
		chk(flags_o, fl);
	endtask

	initial begin
		cycles = 0;
		err_count = 0;
		checked = 0;
		rst_n_i = 1'b0;
		instr_valid_i = 1'b0;
		instr_i = 16'h0000;
		bank_select_register_i = 4'hA;
		file_rdata_i = 8'h00;
		wake_i = 1'b0;
		wake_by_watchdog_i = 1'b0;
		w = 8'h00;
		fl = 5'h00;
		repeat (2) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		// Values left by reset
		chk(working_register_o, 0);
		chk(flags_o, 0);
		chk(timeout_status_bit_o, 1);
		chk(powerdown_status_bit_o, 1);
		chk(osc_stop_o, 0);
		t_literal();
		t_borrow();
		t_file();
		t_sleep(1'b1);
		t_sleep(1'b0);
		run(2, 1'b0, 1'b0, 8'h00, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire

// ---- logic/sbw_alu.sv ----
// Purpose: Subtract instructions and sleep tail of an 8-bit core.
// Assumes: One instruction accepted per four-phase cycle, file read in Q2.
// Notes: Sleep halts the phase sequencer until wake_i.
`include "sbw_defines.svh"
`default_nettype none
module sbw_alu (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [3:0] bank_select_register_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic wake_i,
	input wire logic wake_by_watchdog_i,
	output logic instr_ready_o,
	output logic [3:0] phase_o,
	output logic [11:0] file_addr_o,
	output logic file_rd_o,
	output logic file_we_o,
	output logic [7:0] file_wdata_o,
	output logic [7:0] working_register_o,
	output sbw_pkg::sbw_flags_type flags_o,
	output logic timeout_status_bit_o,
	output logic powerdown_status_bit_o,
	output logic watchdog_counter_clr_o,
	output logic osc_stop_o
);
	sbw_pkg::sbw_state_type st_reg;
	sbw_pkg::sbw_state_type st_next;
	logic [7:0] alu_res;
	sbw_pkg::sbw_flags_type alu_flags;
	logic is_sfwb;
	logic is_sub_work_from_file;
	logic is_sub_work_from_literal;
	logic is_sleep;

	sbw_sub_unit u_sub (
		.a_i(st_reg.opa),
		.b_i(st_reg.opb),
		.cin_i(st_reg.cin),
		.res_o(alu_res),
		.flags_o(alu_flags)
	);

	// Opcode match on fixed bits
	assign is_sfwb = (instr_i & `SBW_OPC_SFWB_MASK) == `SBW_OPC_SFWB;
	assign is_sub_work_from_file = (instr_i & `SBW_OPC_SFWB_MASK) == `SBW_OPC_SUB_WORK_FROM_FILE;
	assign is_sub_work_from_literal = (instr_i & `SBW_OPC_SUB_WORK_FROM_LITERAL_MASK) == `SBW_OPC_SUB_WORK_FROM_LITERAL;
	assign is_sleep = instr_i == `SBW_OPC_SLEEP;

	// Sequencer and datapath next state
	always_comb begin
		st_next = st_reg;
		st_next.rd = 1'b0;
		st_next.we = 1'b0;
		st_next.wdt_clr = 1'b0;
		if (st_reg.asleep) begin
			// Sequencer frozen; only a wake event moves it
			if (wake_i) begin
				st_next.asleep = 1'b0;
				st_next.phase = sbw_pkg::SBW_Q1;
				if (wake_by_watchdog_i) begin
					st_next.to_bit = 1'b0; // see (RULE6)
				end
			end
		end else begin
			unique case (st_reg.phase)
				sbw_pkg::SBW_Q1: begin
					// Decode and form the file address
					st_next.phase = sbw_pkg::SBW_Q2; // see (RULE8)
					st_next.op = sbw_pkg::SBW_OP_NONE;
					st_next.dst_file = instr_i[`SBW_BIT_DEST];
					st_next.fsel = instr_i[7:0];
					if (instr_i[`SBW_BIT_BANK]) begin
						// see (RULE3)
						st_next.addr = {bank_select_register_i, instr_i[7:0]};
					end else if (instr_i[7:0] < `SBW_ACC_SPLIT) begin
						st_next.addr = {`SBW_ACC_LO_BANK, instr_i[7:0]}; // see (RULE3)
					end else begin
						st_next.addr = {`SBW_ACC_HI_BANK, instr_i[7:0]}; // see (RULE3)
					end
					if (instr_valid_i) begin
						if (is_sfwb) begin
							st_next.op = sbw_pkg::SBW_OP_SFWB;
							st_next.rd = 1'b1;
						end else if (is_sub_work_from_file) begin
							st_next.op = sbw_pkg::SBW_OP_SUB_WORK_FROM_FILE;
							st_next.rd = 1'b1;
						end else if (is_sub_work_from_literal) begin
							st_next.op = sbw_pkg::SBW_OP_SUB_WORK_FROM_LITERAL;
							st_next.dst_file = 1'b0;
						end else if (is_sleep) begin
							st_next.op = sbw_pkg::SBW_OP_SLEEP;
						end
					end
				end
				sbw_pkg::SBW_Q2: begin
					// Operand read; order depends on the instruction
					st_next.phase = sbw_pkg::SBW_Q3;
					st_next.cin = 1'b1;
					if (st_reg.op == sbw_pkg::SBW_OP_SFWB) begin
						st_next.opa = st_reg.working_register; // see (RULE1)
						st_next.opb = file_rdata_i;
						st_next.cin = st_reg.flags.c; // see (RULE1)
					end else if (st_reg.op == sbw_pkg::SBW_OP_SUB_WORK_FROM_FILE) begin
						st_next.opa = file_rdata_i;
						st_next.opb = st_reg.working_register;
					end else begin
						st_next.opa = st_reg.fsel; // Literal k
						st_next.opb = st_reg.working_register;
					end
				end
				sbw_pkg::SBW_Q3: begin
					// Process; result held for the write phase
					st_next.phase = sbw_pkg::SBW_Q4;
					st_next.res = alu_res;
					st_next.rflags = alu_flags;
					if (st_reg.dst_file && (st_reg.op == sbw_pkg::SBW_OP_SFWB ||
						st_reg.op == sbw_pkg::SBW_OP_SUB_WORK_FROM_FILE)) begin
						st_next.we = 1'b1; // see (RULE2)
						st_next.wdata = alu_res;
					end
				end
				sbw_pkg::SBW_Q4: begin
					// Write destination or go to sleep
					st_next.phase = sbw_pkg::SBW_Q1;
					if (st_reg.op == sbw_pkg::SBW_OP_SLEEP) begin
						st_next.pd_bit = 1'b0; // see (RULE7)
						st_next.to_bit = 1'b1; // see (RULE7)
						st_next.wdt_clr = 1'b1; // see (RULE7)
						st_next.asleep = 1'b1; // see (RULE7)
					end else if (st_reg.op != sbw_pkg::SBW_OP_NONE) begin
						st_next.flags = st_reg.rflags; // see (RULE8) (RULE4)
						if (!st_reg.dst_file) begin
							st_next.working_register = st_reg.res; // see (RULE2)
						end
					end
				end
			endcase
		end
	end

	// State register, synchronous reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
			st_reg.phase <= sbw_pkg::SBW_Q1;
			st_reg.op <= sbw_pkg::SBW_OP_NONE;
			st_reg.working_register <= `SBW_RST_WORKING_REGISTER;
			st_reg.to_bit <= `SBW_RST_TO;
			st_reg.pd_bit <= `SBW_RST_PD;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state
	assign instr_ready_o = (st_reg.phase == sbw_pkg::SBW_Q1) && !st_reg.asleep;
	assign phase_o = st_reg.phase;
	assign file_addr_o = st_reg.addr;
	assign file_rd_o = st_reg.rd;
	assign file_we_o = st_reg.we;
	assign file_wdata_o = st_reg.wdata;
	assign working_register_o = st_reg.working_register;
	assign flags_o = st_reg.flags;
	assign timeout_status_bit_o = st_reg.to_bit;
	assign powerdown_status_bit_o = st_reg.pd_bit;
	assign watchdog_counter_clr_o = st_reg.wdt_clr;
	assign osc_stop_o = st_reg.asleep;

	// Checks on the datapath and sequencer
	property p_borrow_calc;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q3 && !st_reg.asleep &&
			st_reg.op == sbw_pkg::SBW_OP_SFWB) |=>
		st_reg.res == 8'($past(st_reg.opa) - $past(st_reg.opb)
			- {7'h00, !$past(st_reg.cin)});
	endproperty
	a_borrow_calc: assert property (p_borrow_calc) // see (RULE1)
		else $error("borrow subtract result wrong");

	property p_dest_file;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q3 && !st_reg.asleep &&
			st_reg.dst_file && st_reg.op == sbw_pkg::SBW_OP_SUB_WORK_FROM_FILE) |=>
		file_we_o && file_wdata_o == st_reg.res ##1
		working_register_o == $past(working_register_o, 2);
	endproperty
	a_dest_file: assert property (p_dest_file) // see (RULE2)
		else $error("file destination write wrong");

	property p_dest_work;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q4 && !st_reg.asleep &&
			!st_reg.dst_file && st_reg.op == sbw_pkg::SBW_OP_SFWB) |->
		!file_we_o ##1 working_register_o == $past(st_reg.res);
	endproperty
	a_dest_work: assert property (p_dest_work) // see (RULE2)
		else $error("working register destination wrong");

	property p_bank_sel;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(instr_ready_o && instr_i[`SBW_BIT_BANK]) |=>
		file_addr_o == {$past(bank_select_register_i), $past(instr_i[7:0])};
	endproperty
	a_bank_sel: assert property (p_bank_sel) // see (RULE3)
		else $error("bank select address wrong");

	property p_access_bank;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(instr_ready_o && !instr_i[`SBW_BIT_BANK]) |=>
		file_addr_o[11:8] == ($past(instr_i[7]) ? `SBW_ACC_HI_BANK
			: `SBW_ACC_LO_BANK);
	endproperty
	a_access_bank: assert property (p_access_bank) // see (RULE3)
		else $error("access bank address wrong");

	property p_zero_flags;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q4 && !st_reg.asleep &&
			st_reg.op == sbw_pkg::SBW_OP_SFWB && st_reg.res == 8'h00) |=>
		flags_o.z && flags_o.c;
	endproperty
	a_zero_flags: assert property (p_zero_flags) // see (RULE4)
		else $error("zero result flags wrong");

	property p_borrow_flags;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q3 && !st_reg.asleep &&
			st_reg.op != sbw_pkg::SBW_OP_NONE &&
			st_reg.op != sbw_pkg::SBW_OP_SLEEP) |=> ##1
		flags_o.n == $past(st_reg.res[7]) && flags_o.c == ({1'b0,
			$past(st_reg.opa, 2)} >= {1'b0, $past(st_reg.opb, 2)} +
			{8'h00, !$past(st_reg.cin, 2)});
	endproperty
	a_borrow_flags: assert property (p_borrow_flags) // see (RULE5)
		else $error("negative or borrow flag wrong");

	property p_wdt_wake;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.asleep && wake_i && wake_by_watchdog_i) |=>
		!timeout_status_bit_o && !osc_stop_o;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) // see (RULE6)
		else $error("watchdog wake did not clear timeout");

	property p_sleep_entry;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_reg.phase == sbw_pkg::SBW_Q4 && !st_reg.asleep &&
			st_reg.op == sbw_pkg::SBW_OP_SLEEP) |=>
		!powerdown_status_bit_o && timeout_status_bit_o &&
		watchdog_counter_clr_o && osc_stop_o ##1 !watchdog_counter_clr_o;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) // see (RULE7)
		else $error("sleep entry status wrong");

	property p_four_phase;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(instr_ready_o && instr_valid_i && is_sfwb) |=>
		phase_o == sbw_pkg::SBW_Q2 ##1 phase_o == sbw_pkg::SBW_Q3 ##1
		phase_o == sbw_pkg::SBW_Q4 ##1 phase_o == sbw_pkg::SBW_Q1;
	endproperty
	a_four_phase: assert property (p_four_phase) // see (RULE8)
		else $error("subtract did not take four phases");

	c_sfwb: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_reg.phase == sbw_pkg::SBW_Q4 && st_reg.op == sbw_pkg::SBW_OP_SFWB);
	c_sleep: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(osc_stop_o));
	c_wdt_wake: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_reg.asleep && wake_i && wake_by_watchdog_i);
	c_sub_work_from_literal: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_reg.phase == sbw_pkg::SBW_Q4 && st_reg.op == sbw_pkg::SBW_OP_SUB_WORK_FROM_LITERAL);
endmodule
`default_nettype wire

// ---- logic/sbw_defines.svh ----
// Purpose: Constants for the subtract-with-borrow datapath slice.
// Assumes: 16-bit instruction words, 8-bit data, 12-bit file address.
// Notes: Opcodes are matched on their fixed upper bits; SLEEP is matched on the whole word.
// Function
// (RULE1) The borrow subtract gives working register minus file minus not-C.
// (RULE2) Destination bit 0 writes the working register, 1 writes the file.
// (RULE3) Bank bit 0 picks the access bank, 1 picks the bank select register.
// (RULE4) A zero subtract result sets zero and sets carry for no borrow.
// (RULE5) A borrow clears carry, negative follows bit 7 of the result.
// (RULE6) A wake-up caused by the watchdog clears the timeout status bit.
// (RULE7) Sleep clears powerdown, sets timeout, clears watchdog, stops clock.
// (RULE8) Each subtract takes one cycle of four phases and updates N,OV,C,DC,Z.
`ifndef SBW_DEFINES_SVH
`define SBW_DEFINES_SVH
`define SBW_OPC_SFWB_MASK 16'hFC00
`define SBW_OPC_SFWB 16'h5400
`define SBW_OPC_SUB_WORK_FROM_FILE 16'h5C00
`define SBW_OPC_SUB_WORK_FROM_LITERAL_MASK 16'hFF00
`define SBW_OPC_SUB_WORK_FROM_LITERAL 16'h0800
`define SBW_OPC_SLEEP 16'h0003
`define SBW_BIT_DEST 9
`define SBW_BIT_BANK 8
`define SBW_ACC_SPLIT 8'h80
`define SBW_ACC_LO_BANK 4'h0
`define SBW_ACC_HI_BANK 4'hF
`define SBW_RST_WORKING_REGISTER 8'h00
`define SBW_RST_TO 1'b1
`define SBW_RST_PD 1'b1
`endif

// ---- logic/sbw_pkg.sv ----
// Purpose: Types for the subtract-with-borrow datapath slice.
// Assumes: One-hot phase and operation codes.
// Notes: The whole module state is one packed struct.
`default_nettype none
package sbw_pkg;
	typedef enum logic [3:0] {
		SBW_Q1 = 4'h1,
		SBW_Q2 = 4'h2,
		SBW_Q3 = 4'h4,
		SBW_Q4 = 4'h8
	} sbw_phase_type;
	typedef enum logic [4:0] {
		SBW_OP_NONE = 5'h01,
		SBW_OP_SFWB = 5'h02,
		SBW_OP_SUB_WORK_FROM_FILE = 5'h04,
		SBW_OP_SUB_WORK_FROM_LITERAL = 5'h08,
		SBW_OP_SLEEP = 5'h10
	} sbw_op_type;
	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} sbw_flags_type;
	typedef struct packed {
		sbw_phase_type phase;
		sbw_op_type op;
		logic dst_file;
		logic [7:0] fsel;
		logic [7:0] opa;
		logic [7:0] opb;
		logic cin;
		logic [7:0] res;
		sbw_flags_type rflags;
		logic [7:0] working_register;
		sbw_flags_type flags;
		logic to_bit;
		logic pd_bit;
		logic asleep;
		logic [11:0] addr;
		logic rd;
		logic we;
		logic [7:0] wdata;
		logic wdt_clr;
	} sbw_state_type;
endpackage
`default_nettype wire

// ---- logic/sbw_sub_unit.sv ----
// Purpose: Eight-bit subtract a - b - not(cin) with status flags.
// Assumes: cin high means no borrow pending.
// Notes: Purely combinational; carry out high means no borrow.
`default_nettype none
module sbw_sub_unit (
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	output logic [7:0] res_o,
	output sbw_pkg::sbw_flags_type flags_o
);
	logic [8:0] sum;
	logic [4:0] low;
	// Two's complement add of the inverted subtrahend
	always_comb begin
		sum = {1'b0, a_i} + {1'b0, ~b_i} + {8'h00, cin_i}; // see (RULE1)
		low = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + {4'h0, cin_i};
		res_o = sum[7:0];
		flags_o.c = sum[8]; // see (RULE4) (RULE5)
		flags_o.dc = low[4];
		flags_o.z = (sum[7:0] == 8'h00); // see (RULE4)
		flags_o.n = sum[7]; // see (RULE5)
		flags_o.ov = (a_i[7] != b_i[7]) && (sum[7] != a_i[7]);
	end
endmodule
`default_nettype wire
